//--- core/input_fault_protect_regs.sv
// Purpose: Input fault protection commands, status and alert for a dual channel converter.
// Assumes: Host drives the link clock; pins are sampled by clk at 10 MHz.
// Notes: No page input exists, so every command acts on both channels.
module input_fault_protect_regs
	import input_fault_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h40,
	parameter int EN_PINS = 2
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic resetn,
	// Management link pins.
	input wire logic sclPin,
	input wire logic sdaPin,
	output logic sdaOut,
	output logic sdaOe,
	// Host alert pin, open drain.
	output logic alertOut,
	output logic alertOe,
	// Measurements, limits, turn-on and enable states from the converter.
	input wire logic [7:0] vinHalfVolts,
	input wire logic [7:0] iinHalfAmps,
	input wire logic [4:0] ovLimitVolts,
	input wire logic vinAboveTurnOn,
	input wire logic unitEnabled,
	input wire logic operationOn,
	input wire logic [EN_PINS-1:0] channelEnablePins,
	// Non-volatile storage.
	input wire logic [15:0] nvmUvLimit,
	input wire logic [15:0] nvmOcLimit,
	input wire logic restoreAll,
	// Power stage control.
	output logic convertOn
);
	link_s ev;
	fault_s faults;
	link_state_e state;
	logic enableDrop;
	logic [2:0] bitCnt;
	logic [7:0] shiftReg;
	logic [7:0] txShift;
	logic [1:0] byteIdx;
	logic isRead;
	logic sentHigh;
	logic [7:0] cmdReg;
	logic [7:0] dataLow;
	logic [15:0] readData;
	logic [15:0] wordIn;
	logic byteValid;
	logic wrWord;
	logic wrMask;
	logic clearPulse;
	logic loadPending;
	logic loadNvm;
	logic [15:0] uvLimit;
	logic [6:0] ocMan;
	logic [7:0] alertMask;
	logic [7:0] statusIn;
	logic [7:0] setBits;
	logic [15:0] statusWord;
	logic ocLatched;
	logic opPrev;
	logic opFall;

	function automatic logic uvValid(input logic [15:0] w);
		return w[15:11] == UV_EXPONENT && w[10:0] >= UV_MAN_MIN && w[10:0] <= UV_MAN_MAX
			&& w[0];
	endfunction : uvValid

	function automatic logic ocValid(input logic [15:0] w);
		return w[15:11] == OC_EXPONENT && w[10:7] == 4'h0;
	endfunction : ocValid

	function automatic logic ocKeep(input logic [15:0] w);
		return ocValid(w) && ((w[3:0] == 4'h0 && w[6:4] != 3'h0) || w[6:0] == OC_MAN_MAX);
	endfunction : ocKeep

	////////////////////////////////////////////////////////////////////////////
	smbus_link u_link (
		.clk(clk),
		.resetn(resetn),
		.sclPin(sclPin),
		.sdaPin(sdaPin),
		.events(ev)
	);

	fault_monitor #(
		.EN_PINS(EN_PINS)
	) u_monitor (
		.clk(clk),
		.resetn(resetn),
		.vinHalfVolts(vinHalfVolts),
		.iinHalfAmps(iinHalfAmps),
		.ovLimitVolts(ovLimitVolts),
		.uvLimitHalf(uvLimit[7:0]),
		.ocLimitHalf(ocMan),
		.vinAboveTurnOn(vinAboveTurnOn),
		.unitEnabled(unitEnabled),
		.channelEnablePins(channelEnablePins),
		.faults(faults),
		.enableDrop(enableDrop)
	);

	////////////////////////////////////////////////////////////////////////////
	// Byte engine. The answer bit changes only after a falling clock edge.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state <= ST_IDLE;
			bitCnt <= 3'h0;
			shiftReg <= 8'h00;
			txShift <= 8'h00;
			byteIdx <= IDX_ADDR;
			isRead <= 1'b0;
			sentHigh <= 1'b0;
			cmdReg <= 8'h00;
			dataLow <= 8'h00;
			sdaOe <= 1'b0;
		end else if (ev.stop) begin
			state <= ST_IDLE;
			sdaOe <= 1'b0;
		end else if (ev.start) begin
			state <= ST_RECV;
			bitCnt <= 3'h0;
			byteIdx <= IDX_ADDR;
			sdaOe <= 1'b0;
		end else begin
			case (state)
				ST_RECV: begin
					if (ev.rise) begin
						shiftReg <= {shiftReg[6:0], ev.sda};
						bitCnt <= bitCnt + 3'h1;
						if (bitCnt == BIT_LAST) begin
							state <= ST_DECIDE;
						end
					end
				end
				ST_DECIDE: begin
					if (ev.fall) begin
						if (byteIdx == IDX_ADDR && shiftReg[7:1] != DEV_ADDR) begin
							state <= ST_IDLE;
						end else begin
							sdaOe <= 1'b1;
							state <= ST_ACK;
						end
						if (byteIdx == IDX_ADDR) begin
							isRead <= shiftReg[0];
						end
						if (byteIdx == IDX_CMD) begin
							cmdReg <= shiftReg;
						end
						if (byteIdx == IDX_LOW) begin
							dataLow <= shiftReg;
						end
					end
				end
				ST_ACK: begin
					if (ev.fall) begin
						bitCnt <= 3'h0;
						byteIdx <= (byteIdx == IDX_HIGH) ? IDX_HIGH : byteIdx + 2'h1;
						if (byteIdx == IDX_ADDR && isRead) begin
							txShift <= readData[7:0];
							sdaOe <= ~readData[7];
							sentHigh <= 1'b0;
							state <= ST_SEND;
						end else begin
							sdaOe <= 1'b0;
							state <= ST_RECV;
						end
					end
				end
				ST_SEND: begin
					if (ev.fall) begin
						if (bitCnt == BIT_LAST) begin
							sdaOe <= 1'b0;
							state <= ST_MACK;
						end else begin
							txShift <= {txShift[6:0], 1'b0};
							sdaOe <= ~txShift[6];
							bitCnt <= bitCnt + 3'h1;
						end
					end
				end
				ST_MACK: begin
					if (ev.rise && ev.sda) begin
						state <= ST_IDLE;
					end else if (ev.fall) begin
						txShift <= sentHigh ? 8'h00 : readData[15:8];
						sdaOe <= sentHigh ? 1'b0 : ~readData[15];
						sentHigh <= 1'b1;
						bitCnt <= 3'h0;
						state <= ST_SEND;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	assign byteValid = state == ST_DECIDE && ev.fall && !isRead
		&& byteIdx != IDX_ADDR;
	assign wordIn = {shiftReg, dataLow};
	assign wrWord = byteValid && byteIdx == IDX_HIGH;
	assign wrMask = byteValid && byteIdx == IDX_LOW && cmdReg == CMD_ALERT_MASK;
	assign clearPulse = byteValid && byteIdx == IDX_CMD && shiftReg == CMD_CLEAR_FAULTS;

	always_comb begin
		case (cmdReg)
			CMD_OV_ACTION: readData = {8'h00, OV_ACTION_CODE};
			CMD_UV_LIMIT: readData = uvLimit;
			CMD_UV_ACTION: readData = {8'h00, UV_ACTION_CODE};
			CMD_OC_LIMIT: readData = {OC_EXPONENT, 4'h0, ocMan};
			CMD_ALERT_MASK: readData = {8'h00, alertMask};
			CMD_STATUS_BYTE: readData = {8'h00, statusWord[7:0]};
			CMD_STATUS_WORD: readData = statusWord;
			CMD_STATUS_INPUT: readData = {8'h00, statusIn};
			default: readData = 16'h0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Storage is sampled one cycle after reset release, never under reset.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			loadPending <= 1'b1;
		end else begin
			loadPending <= 1'b0;
		end
	end
	assign loadNvm = loadPending || restoreAll;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			uvLimit <= UV_LIMIT_RESET;
		end else if (loadNvm) begin
			uvLimit <= uvValid(nvmUvLimit) ? nvmUvLimit : UV_LIMIT_RESET;
		end else if (wrWord && cmdReg == CMD_UV_LIMIT && uvValid(wordIn)) begin
			uvLimit <= wordIn;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			ocMan <= OC_MAN_MAX;
		end else if (loadNvm) begin
			ocMan <= ocKeep(nvmOcLimit) ? nvmOcLimit[6:0] : OC_MAN_MAX;
		end else if (wrWord && cmdReg == CMD_OC_LIMIT && ocValid(wordIn)) begin
			ocMan <= wordIn[6:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			alertMask <= ALERT_MASK_RESET;
		end else if (wrMask) begin
			alertMask <= shiftReg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		setBits = 8'h00;
		setBits[IN_OV_BIT] = faults.ov;
		setBits[IN_UV_BIT] = faults.uv;
		setBits[IN_OC_BIT] = faults.oc;
		statusWord = 16'h0000;
		statusWord[INPUT_BIT] = |statusIn;
		statusWord[OTHER_BIT] = |statusIn;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			statusIn <= 8'h00;
		end else begin
			statusIn <= (statusIn & ~{8{clearPulse}}) | setBits;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			alertOe <= 1'b0;
		end else begin
			alertOe <= |(statusIn & ~alertMask);
		end
	end

	// Both open-drain pins only ever pull low.
	always_ff @(posedge clk) begin
		sdaOut <= 1'b0;
		alertOut <= 1'b0;
	end

	assign opFall = opPrev && !operationOn;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			opPrev <= 1'b0;
			ocLatched <= 1'b0;
		end else begin
			opPrev <= operationOn;
			if (faults.oc) begin
				ocLatched <= 1'b1;
			end else if (enableDrop || opFall) begin
				ocLatched <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			convertOn <= 1'b0;
		end else begin
			convertOn <= vinAboveTurnOn && unitEnabled && !faults.uv && !faults.oc
				&& !ocLatched;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	property p_ovStatus;
		faults.ov |=> statusIn[IN_OV_BIT] && statusWord[INPUT_BIT] && statusWord[OTHER_BIT];
	endproperty
	a_ovStatus: assert property (p_ovStatus) else $error("ov status not set");

	property p_ovAlert;
		(faults.ov && !alertMask[IN_OV_BIT] && !wrMask) |=> ##1 alertOe;
	endproperty
	a_ovAlert: assert property (p_ovAlert) else $error("ov alert missing");

	property p_ovRuns;
		(vinAboveTurnOn && unitEnabled && faults.ov && !faults.uv && !faults.oc && !ocLatched)
			|=> convertOn;
	endproperty
	a_ovRuns: assert property (p_ovRuns) else $error("ov stopped conversion");

	sequence s_uvFlagThenAlert;
		statusIn[IN_UV_BIT] ##1 alertOe;
	endsequence
	property p_uvAlert;
		(faults.uv && !alertMask[IN_UV_BIT] && !wrMask) |=> s_uvFlagThenAlert;
	endproperty
	a_uvAlert: assert property (p_uvAlert) else $error("uv status or alert missing");

	property p_uvShutdown;
		faults.uv |=> !convertOn;
	endproperty
	a_uvShutdown: assert property (p_uvShutdown) else $error("uv did not stop");

	sequence s_ocTripQuiet;
		faults.oc ##1 !(enableDrop || opFall);
	endsequence
	property p_ocLatch;
		s_ocTripQuiet |=> ocLatched && !convertOn;
	endproperty
	a_ocLatch: assert property (p_ocLatch) else $error("oc latch lost");

	property p_sticky;
		(statusIn[IN_UV_BIT] && !clearPulse) |=> statusIn[IN_UV_BIT];
	endproperty
	a_sticky: assert property (p_sticky) else $error("status bit dropped");

	property p_clear;
		(clearPulse && !faults.uv) |=> !statusIn[IN_UV_BIT];
	endproperty
	a_clear: assert property (p_clear) else $error("clear ignored");

	property p_badOc;
		(wrWord && cmdReg == CMD_OC_LIMIT && !ocValid(wordIn) && !loadNvm) |=> $stable(ocMan);
	endproperty
	a_badOc: assert property (p_badOc) else $error("bad oc limit taken");

	property p_restoreFull;
		(loadNvm && !ocKeep(nvmOcLimit)) |=> ocMan == OC_MAN_MAX;
	endproperty
	a_restoreFull: assert property (p_restoreFull) else $error("oc restore not full");

	property p_restoreKeep;
		(loadNvm && ocKeep(nvmOcLimit)) |=> ocMan == $past(nvmOcLimit[6:0]);
	endproperty
	a_restoreKeep: assert property (p_restoreKeep) else $error("oc restore changed");

	property p_uvWrite;
		(wrWord && cmdReg == CMD_UV_LIMIT && uvValid(wordIn) && !loadNvm)
			|=> uvLimit == $past(wordIn);
	endproperty
	a_uvWrite: assert property (p_uvWrite) else $error("uv limit not written");
endmodule : input_fault_protect_regs

//--- core/input_fault_pkg.sv
// Purpose: Shared constants and types for the input fault protection registers.
// Assumes: Commands are reached over the two-wire management link only.
// Notes: Measurements arrive in half units (0.5 V, 0.5 A per count).
package input_fault_pkg;
	// Command codes.
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_ALERT_MASK = 8'h1b;
	localparam logic [7:0] CMD_OV_ACTION = 8'h56;
	localparam logic [7:0] CMD_UV_LIMIT = 8'h59;
	localparam logic [7:0] CMD_UV_ACTION = 8'h5a;
	localparam logic [7:0] CMD_OC_LIMIT = 8'h5b;
	localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
	localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
	localparam logic [7:0] CMD_STATUS_INPUT = 8'h7c;
	// Fixed answers and reset values.
	localparam logic [7:0] OV_ACTION_CODE = 8'h00;
	localparam logic [7:0] UV_ACTION_CODE = 8'hc0;
	localparam logic [15:0] UV_LIMIT_RESET = 16'hf80f;
	localparam logic [7:0] ALERT_MASK_RESET = 8'h00;
	localparam logic [6:0] OC_MAN_MAX = 7'h7f;
	// Field positions and encodings.
	localparam int OTHER_BIT = 0;
	localparam int INPUT_BIT = 13;
	localparam int IN_OV_BIT = 7;
	localparam int IN_UV_BIT = 4;
	localparam int IN_OC_BIT = 2;
	localparam logic [4:0] OC_EXPONENT = 5'h1f;
	localparam logic [4:0] UV_EXPONENT = 5'h1f;
	localparam logic [10:0] UV_MAN_MIN = 11'h00d;
	localparam logic [10:0] UV_MAN_MAX = 11'h017;
	// Link byte handling.
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [1:0] IDX_ADDR = 2'h0;
	localparam logic [1:0] IDX_CMD = 2'h1;
	localparam logic [1:0] IDX_LOW = 2'h2;
	localparam logic [1:0] IDX_HIGH = 2'h3;

	typedef struct packed {
		logic ov;
		logic uv;
		logic oc;
	} fault_s;

	typedef struct packed {
		logic start;
		logic stop;
		logic rise;
		logic fall;
		logic sda;
	} link_s;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RECV = 3'b001,
		ST_DECIDE = 3'b010,
		ST_ACK = 3'b011,
		ST_SEND = 3'b100,
		ST_MACK = 3'b101
	} link_state_e;
endpackage : input_fault_pkg

//--- core/smbus_link.sv
// Purpose: Samples the link clock and data pins and reports bus events.
// Assumes: The system clock runs several times faster than the link clock.
// Notes: Both pins see the same two-stage latency, so their relative timing holds.
module smbus_link
	import input_fault_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic resetn,
	// Bus pins.
	input wire logic sclPin,
	input wire logic sdaPin,
	// Decoded events.
	output link_s events
);
	logic [1:0] sclSync;
	logic [1:0] sdaSync;
	logic sclPrev;
	logic sdaPrev;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			sclSync <= 2'h3;
			sdaSync <= 2'h3;
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
		end else begin
			sclSync <= {sclSync[0], sclPin};
			sdaSync <= {sdaSync[0], sdaPin};
			sclPrev <= sclSync[1];
			sdaPrev <= sdaSync[1];
		end
	end

	// A data edge while the clock is high frames a transfer.
	assign events.start = sclSync[1] && sclPrev && sdaPrev && !sdaSync[1];
	assign events.stop = sclSync[1] && sclPrev && !sdaPrev && sdaSync[1];
	assign events.rise = sclSync[1] && !sclPrev;
	assign events.fall = !sclSync[1] && sclPrev;
	assign events.sda = sdaSync[1];
endmodule : smbus_link

//--- core/fault_monitor.sv
// Purpose: Compares input measurements with the limits and tracks enable pins.
// Assumes: Measurements and limits come from logic on the same clock.
// Notes: Fault levels are registered, one cycle behind the measurements.
module fault_monitor
	import input_fault_pkg::*;
#(
	parameter int EN_PINS = 2
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic resetn,
	// Measurements and limits.
	input wire logic [7:0] vinHalfVolts,
	input wire logic [7:0] iinHalfAmps,
	input wire logic [4:0] ovLimitVolts,
	input wire logic [7:0] uvLimitHalf,
	input wire logic [6:0] ocLimitHalf,
	// Arming conditions and channel enable pins.
	input wire logic vinAboveTurnOn,
	input wire logic unitEnabled,
	input wire logic [EN_PINS-1:0] channelEnablePins,
	// Results.
	output fault_s faults,
	output logic enableDrop
);
	logic uvArmed;
	logic [EN_PINS-1:0] dropBits;

	for (genvar i = 0; i < EN_PINS; i++) begin : g_pin
		logic meta;
		logic sync;
		logic prev;
		always_ff @(posedge clk) begin
			if (!resetn) begin
				meta <= 1'b0;
				sync <= 1'b0;
				prev <= 1'b0;
			end else begin
				meta <= channelEnablePins[i];
				sync <= meta;
				prev <= sync;
			end
		end
		assign dropBits[i] = prev && !sync;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			uvArmed <= 1'b0;
		end else if (vinAboveTurnOn && unitEnabled) begin
			uvArmed <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			faults <= '0;
			enableDrop <= 1'b0;
		end else begin
			faults.ov <= vinHalfVolts > {2'h0, ovLimitVolts, 1'b0};
			faults.uv <= uvArmed && (vinHalfVolts < uvLimitHalf);
			faults.oc <= iinHalfAmps > {1'b0, ocLimitHalf};
			enableDrop <= |dropBits;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	property p_uvMasked;
		!uvArmed |=> !faults.uv;
	endproperty
	a_uvMasked: assert property (p_uvMasked) else $error("uv fault while unarmed");

	property p_ocCompare;
		(iinHalfAmps > {1'b0, ocLimitHalf}) |=> faults.oc;
	endproperty
	a_ocCompare: assert property (p_ocCompare) else $error("oc fault missed");
endmodule : fault_monitor

//--- testbench/smbus_host_model.sv
// Purpose: Behavioural host that runs byte and word transfers on the link.
// Assumes: The host drives the clock line alone; the data line is open drain with a pull-up; sdaWire is the resolved line.
// Notes: One bit takes 8 clk (800 ns); the clock line rests high between frames.
module smbus_host_model #(
	parameter logic [6:0] ADDR = 7'h40
) (
	// Clock.
	input wire logic clk,
	// Link lines.
	output logic sclPin,
	output logic sdaLow,
	input wire logic sdaWire,
	// Results.
	output logic rdValid,
	output logic [15:0] rdData,
	output logic nackSeen
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		sclPin = 1'b1;
		sdaLow = 1'b0;
		rdValid = 1'b0;
		rdData = 16'h0000;
		nackSeen = 1'b0;
	end
	////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	// Data moves only while the clock is low, so no false start or stop is seen.
	task automatic bitx(input logic b, output logic got);
		tick(1);
		sdaLow <= ~b;
		tick(4);
		sclPin <= 1'b1;
		tick(2);
		got = sdaWire;
		tick(1);
		sclPin <= 1'b0;
	endtask : bitx
	task automatic xfer(input logic [7:0] tx, input logic ackIn, output logic [7:0] rx,
		input logic chk);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bitx(tx[i], rx[i]);
		end
		bitx(ackIn, a);
		if (chk && a) begin
			nackSeen <= 1'b1;
		end
	endtask : xfer
	task automatic start();
		sdaLow <= 1'b1;
		tick(4);
		sclPin <= 1'b0;
	endtask : start
	task automatic stop();
		tick(1);
		sdaLow <= 1'b1;
		tick(4);
		sclPin <= 1'b1;
		tick(3);
		sdaLow <= 1'b0;
		tick(8);
	endtask : stop
	task automatic wr(input logic [7:0] cmd, input logic [15:0] d, input int n);
		logic [7:0] r;
		start();
		xfer({ADDR, 1'b0}, 1'b1, r, 1'b1);
		xfer(cmd, 1'b1, r, 1'b1);
		if (n > 0) xfer(d[7:0], 1'b1, r, 1'b1);
		if (n > 1) xfer(d[15:8], 1'b1, r, 1'b1);
		stop();
	endtask : wr
	// byte reads end after one byte
	task automatic rd(input logic [7:0] cmd, input int n);
		logic [7:0] r, lo, hi;
		hi = 8'h00;
		start();
		xfer({ADDR, 1'b0}, 1'b1, r, 1'b1);
		xfer(cmd, 1'b1, r, 1'b1);
		tick(1);
		sdaLow <= 1'b0;
		tick(4);
		sclPin <= 1'b1;
		tick(3);
		start();
		xfer({ADDR, 1'b1}, 1'b1, r, 1'b1);
		xfer(8'hff, n < 2, lo, 1'b0);
		if (n > 1) xfer(8'hff, 1'b1, hi, 1'b0);
		stop();
		rdData <= {hi, lo};
		rdValid <= 1'b1;
		tick(1);
		rdValid <= 1'b0;
	endtask : rd
endmodule : smbus_host_model

//--- testbench/input_fault_protect_regs_bench.sv
// Purpose: Self-checking bench for the input fault protection registers.
// Assumes: The host model owns the link; the bench drives measurements and storage.
// Notes: Expected values queue up and are checked when a read or pin snapshot lands.
module input_fault_protect_regs_bench
	import input_fault_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {
		string name;
		logic [15:0] exp;
		logic [15:0] mask;
	} note_s;
	localparam logic [15:0] ALL = 16'hffff;
	note_s notes[$];
	logic [15:0] wTab [10] = '{16'hf811, 16'hf812, 16'hf819, 16'h0011, 16'hf80d,
		16'hf87f, 16'hf880, 16'hf800, 16'h0810, 16'hf830};
	logic [15:0] eTab [10] = '{16'hf811, 16'hf811, 16'hf811, 16'hf811, 16'hf80d,
		16'hf87f, 16'hf87f, 16'hf800, 16'hf800, 16'hf830};
	logic [15:0] nTab [4] = '{16'hf820, 16'hf87f, 16'hf848, 16'hf800};
	logic [15:0] rTab [4] = '{16'hf820, 16'hf87f, 16'hf87f, 16'hf87f};
	logic clk = 1'b0;
	logic resetn, restoreAll, vinAboveTurnOn, unitEnabled, operationOn, snap;
	logic [7:0] vinHalfVolts, iinHalfAmps;
	logic [4:0] ovLimitVolts;
	logic [1:0] channelEnablePins;
	logic [15:0] nvmUvLimit, nvmOcLimit, ocBoot, rdData;
	logic sclPin, sdaLow, sdaOut, sdaOe, alertOut, alertOe, convertOn, rdValid, nackSeen;
	logic [31:0] seed = 32'h926494c3;
	int miscompares = 0;
	int nChecks = 0;
	wire sdaWire = ~(sdaLow | (sdaOe & ~sdaOut));
	always #50 clk = ~clk;
	input_fault_protect_regs i_input_fault_protect_regs (
		.clk(clk), .resetn(resetn), .sclPin(sclPin), .sdaPin(sdaWire), .sdaOut(sdaOut),
		.sdaOe(sdaOe), .alertOut(alertOut), .alertOe(alertOe), .vinHalfVolts(vinHalfVolts),
		.iinHalfAmps(iinHalfAmps), .ovLimitVolts(ovLimitVolts), .unitEnabled(unitEnabled),
		.vinAboveTurnOn(vinAboveTurnOn), .operationOn(operationOn), .restoreAll(restoreAll),
		.channelEnablePins(channelEnablePins), .nvmUvLimit(nvmUvLimit),
		.nvmOcLimit(nvmOcLimit), .convertOn(convertOn)
	);
	smbus_host_model i_smbus_host_model (
		.clk(clk), .sclPin(sclPin), .sdaLow(sdaLow), .sdaWire(sdaWire), .rdValid(rdValid),
		.rdData(rdData), .nackSeen(nackSeen)
	);
	////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic settle();
		repeat (8) @(posedge clk);
	endtask : settle
	task automatic rd(input logic [7:0] cmd, input int n, input logic [15:0] e,
		input logic [15:0] m);
		notes.push_back('{$sformatf("cmd %h", cmd), e, m});
		i_smbus_host_model.rd(cmd, n);
	endtask : rd
	task automatic wr(input logic [7:0] cmd, input logic [15:0] d, input int n);
		i_smbus_host_model.wr(cmd, d, n);
	endtask : wr
	// Snapshot holds the alert level, the missing acknowledge flag, the alert and the enable.
	task automatic chk_pins(input logic [1:0] e);
		notes.push_back('{"pins", {14'h0000, e}, 16'h000f});
		snap <= 1'b1;
		@(posedge clk);
		snap <= 1'b0;
	endtask : chk_pins
	task automatic close_out();
		if (notes.size() != 0) miscompares++;
		if (miscompares == 0 && nChecks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : close_out
	always @(posedge clk) begin : watch
		note_s n;
		logic [15:0] got;
		if (rdValid || snap) begin
			got = rdValid ? rdData : {12'h000, alertOut, nackSeen, alertOe, convertOn};
			n = notes.pop_front();
			nChecks++;
			if ((got & n.mask) !== (n.exp & n.mask)) begin
				miscompares++;
				$display("mismatch %s expected %h seen %h", n.name, n.exp, got);
			end
		end
	end
	initial begin : watchdog
		repeat (60000) @(posedge clk);
		miscompares++;
		close_out();
	end
	////////////////////////////////////////
	initial begin : main
		ocBoot = {9'h1f0, 3'(1 + rnd() % 7), 4'h0};
		resetn = 1'b0;
		restoreAll = 1'b0;
		vinAboveTurnOn = 1'b0;
		unitEnabled = 1'b0;
		operationOn = 1'b1;
		snap = 1'b0;
		vinHalfVolts = 8'h0a;
		iinHalfAmps = 8'h00;
		ovLimitVolts = 5'h0e;
		channelEnablePins = 2'h3;
		nvmUvLimit = 16'hf813;
		nvmOcLimit = ocBoot;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		settle();
		rd(CMD_OV_ACTION, 1, 16'h0000, ALL);
		rd(CMD_UV_ACTION, 1, 16'h00c0, ALL);
		rd(CMD_UV_LIMIT, 2, 16'hf813, ALL);
		rd(CMD_OC_LIMIT, 2, ocBoot, ALL);
		rd(CMD_STATUS_INPUT, 1, 16'h0000, ALL);
		chk_pins(2'b00);
		wr(CMD_OV_ACTION, 16'h0055, 1);
		rd(CMD_OV_ACTION, 1, 16'h0000, ALL);
		for (int i = 0; i < 10; i++) begin
			wr(i < 5 ? CMD_UV_LIMIT : CMD_OC_LIMIT, wTab[i], 2);
			rd(i < 5 ? CMD_UV_LIMIT : CMD_OC_LIMIT, 2, eTab[i], ALL);
		end
		vinHalfVolts <= 8'h18;
		iinHalfAmps <= 8'(rnd() % 40);
		vinAboveTurnOn <= 1'b1;
		unitEnabled <= 1'b1;
		settle();
		chk_pins(2'b01);
		vinHalfVolts <= 8'h0a;
		settle();
		rd(CMD_STATUS_INPUT, 1, 16'h0010, ALL);
		chk_pins(2'b10);
		vinHalfVolts <= 8'h18;
		settle();
		chk_pins(2'b11);
		rd(CMD_STATUS_INPUT, 1, 16'h0010, ALL);
		wr(CMD_CLEAR_FAULTS, 16'h0000, 0);
		chk_pins(2'b01);
		for (int m = 0; m < 2; m++) begin
			wr(CMD_ALERT_MASK, m ? 16'h0080 : 16'h0000, 1);
			vinHalfVolts <= 8'h28;
			settle();
			rd(CMD_STATUS_INPUT, 1, 16'h0080, ALL);
			rd(CMD_STATUS_BYTE, 1, 16'h0001, 16'h0001);
			rd(CMD_STATUS_WORD, 2, 16'h2000, 16'h2000);
			chk_pins(m ? 2'b01 : 2'b11);
			vinHalfVolts <= 8'h18;
			settle();
			wr(CMD_CLEAR_FAULTS, 16'h0000, 0);
		end
		wr(CMD_ALERT_MASK, 16'h0000, 1);
		iinHalfAmps <= 8'h1e;
		wr(CMD_OC_LIMIT, 16'hf810, 2);
		settle();
		rd(CMD_STATUS_INPUT, 1, 16'h0004, ALL);
		chk_pins(2'b10);
		wr(CMD_OC_LIMIT, 16'hf830, 2);
		iinHalfAmps <= 8'(rnd() % 40);
		wr(CMD_CLEAR_FAULTS, 16'h0000, 0);
		chk_pins(2'b00);
		operationOn <= 1'b0;
		settle();
		operationOn <= 1'b1;
		settle();
		chk_pins(2'b01);
		iinHalfAmps <= 8'h3c;
		settle();
		iinHalfAmps <= 8'h0a;
		wr(CMD_CLEAR_FAULTS, 16'h0000, 0);
		chk_pins(2'b00);
		channelEnablePins <= 2'h1;
		settle();
		channelEnablePins <= 2'h3;
		settle();
		chk_pins(2'b01);
		iinHalfAmps <= 8'h00;
		for (int j = 0; j < 4; j++) begin
			nvmOcLimit <= nTab[j];
			restoreAll <= 1'b1;
			@(posedge clk);
			restoreAll <= 1'b0;
			settle();
			rd(CMD_OC_LIMIT, 2, rTab[j], ALL);
		end
		settle();
		close_out();
	end
endmodule : input_fault_protect_regs_bench
